/* aio_defs.svh */
`ifndef AIO_DEFS_SVH
`define AIO_DEFS_SVH
// ==========================================================
// clock and line rates
`define AIO_CLK_HZ       20000000
`define AIO_BAUD_2400    2400
`define AIO_BAUD_4800    4800
`define AIO_BAUD_9600    9600
`define AIO_BAUD_19200   19200
`define AIO_BAUD_38400   38400
`define AIO_BAUD_57600   57600
`define AIO_BAUD_115200  115200
// line rate selector codes, zero is the factory rate
`define AIO_SEL_9600     3'h0
`define AIO_SEL_2400     3'h1
`define AIO_SEL_4800     3'h2
`define AIO_SEL_19200    3'h3
`define AIO_SEL_38400    3'h4
`define AIO_SEL_57600    3'h5
`define AIO_SEL_115200   3'h6
`define AIO_BOOT_CYCLES  2'h3
`define AIO_RESP_MS      100
// ==========================================================
// configuration values
`define AIO_FACTORY_ADDR 8'h01
`define AIO_DEFAULT_ADDR 8'h00
`define AIO_FACTORY_OUTS 8'h00
// ==========================================================
// characters
`define AIO_CH_CR        8'h0d
`define AIO_CH_HASH      8'h23
`define AIO_CH_DOLLAR    8'h24
`define AIO_CH_PERCENT   8'h25
`define AIO_CH_AT        8'h40
`define AIO_CH_GT        8'h3e
`define AIO_CH_BANG      8'h21
`define AIO_CH_QUERY     8'h3f
`define AIO_CH_COMMA     8'h2c
`define AIO_CH_ZERO      8'h30
`define AIO_CH_ONE       8'h31
`define AIO_CH_SEVEN     8'h37
`define AIO_CH_E         8'h45
`define AIO_CH_A         8'h41
`define AIO_CH_F         8'h46
`define AIO_CH_NINE      8'h39
// ==========================================================
// frame layout
`define AIO_BUF_LEN      4'ha
`define AIO_LEN_STATUS   5'h1b
`define AIO_LEN_SHORT    5'h3
`define AIO_LEN_SETCMD   4'h8
`define AIO_LEN_RDCMD    4'h3
`define AIO_LEN_CKMIN    4'h5
`define AIO_CK_CHARS     4'h2
// ==========================================================
// register map
`define AIO_REG_CFG      8'h00
`define AIO_REG_STATUS   8'h04
`define AIO_REG_OUTS     8'h08
`define AIO_ST_REFUSED   25
`endif

/* aio_pkg.sv */
package aio_pkg;
    typedef enum logic [2:0] {AIO_M_BOOT, AIO_M_HUNT, AIO_M_COLLECT, AIO_M_DECODE,
                              AIO_M_REPLY} aio_main_e;
    typedef enum logic [1:0] {AIO_RX_IDLE, AIO_RX_START, AIO_RX_DATA, AIO_RX_STOP} aio_rx_e;
    typedef enum logic [1:0] {AIO_RP_STATUS, AIO_RP_ACK, AIO_RP_NAK} aio_reply_e;
    typedef struct packed {
        aio_main_e        main;
        logic [1:0]       boot_cnt;
        logic             default_mode;
        logic [7:0]       addr;
        logic [2:0]       baud_sel;
        logic             cksum_en;
        logic [7:0]       outs;
        logic [7:0]       rst_vals;
        logic [7:0]       enc;
        logic [7:0]       enc_snap;
        logic [7:0]       enc_s1;
        logic [7:0]       enc_s2;
        logic [7:0]       enc_s3;
        logic [2:0]       rx_s;
        logic             rx_low;
        logic [2:0]       init_s;
        logic             init_lvl;
        aio_rx_e          rx;
        logic [13:0]      rx_cnt;
        logic [2:0]       rx_bit;
        logic [7:0]       rx_sh;
        logic [9:0][7:0]  fb;
        logic [3:0]       len;
        logic             ovf;
        logic [7:0]       sum;
        aio_reply_e       kind;
        logic [4:0]       idx;
        logic [7:0]       tx_sum;
        logic [9:0]       tx_sh;
        logic [3:0]       tx_left;
        logic [13:0]      tx_cnt;
        logic             tx_low;
        logic             refused;
        logic             wr_pend;
        logic [7:0]       wr_addr;
        logic [31:0]      hrdata;
    } aio_state_s;
endpackage : aio_pkg

/* aio_parser.sv */
// Decided for this implementation: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
`include "aio_defs.svh"
// Notes on behaviour
// - factory: address 01, 9600, no checksum
// - init switch at power-up forces default
// - rate/checksum change only in default state
// - frame: lead, address, command, data, terminator
// - carriage return ends every frame
// - act only on own hex address
// - checksum pair before terminator when enabled
// - checksum is byte sum of preceding chars
// - reply lead: valid '!'/'>', invalid '?'
// - status read is '#', address, return
// - status field one: outputs 7 down 0
// - status field two: reset values 7..0
// - status field three: encoder pins B3..A0
// - rejection reply is '?', address, return
// - set command: '#', address, '1', selector, value
// - selector 00 all, 1n one output
// - selector FF all, En one reset value
// - all-channel value: high nibble channels 7..4
// - single-channel value only 00 or 01
// - factory outputs all off
// - outputs load reset values after reset; hresetn clears rst_vals first, so outputs always come up 00
// - characters: start, eight data, stop
// - reply within 100 ms of frame
module aio_parser (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        rxd,
    output logic             txd,
    output logic             tx_busy,
    input  wire logic        init_switch,
    input  wire logic [3:0]  encoder_phase_a_input,
    input  wire logic [3:0]  encoder_phase_b_input,
    output logic [7:0]       switch_output_channels
);
    // ==========================================================
    // helpers
    function automatic logic [4:0] hexv(input logic [7:0] ch);
        // uppercase only; lowercase letters count as bad digits
        if (ch >= `AIO_CH_ZERO && ch <= `AIO_CH_NINE) begin
            hexv = {1'b1, 4'(ch - `AIO_CH_ZERO)};
        end else if (ch >= `AIO_CH_A && ch <= `AIO_CH_F) begin
            hexv = {1'b1, 4'(ch - `AIO_CH_A + 8'h0a)};
        end else begin
            hexv = 5'h00;
        end
    endfunction : hexv

    function automatic logic [7:0] hexc(input logic [3:0] nib);
        hexc = (nib > 4'h9) ? 8'(`AIO_CH_A + 8'(nib) - 8'h0a) : 8'(`AIO_CH_ZERO + 8'(nib));
    endfunction : hexc

    function automatic logic [13:0] baud_div(input logic [2:0] sel);
        case (sel)
            `AIO_SEL_2400:   baud_div = 14'(`AIO_CLK_HZ / `AIO_BAUD_2400);
            `AIO_SEL_4800:   baud_div = 14'(`AIO_CLK_HZ / `AIO_BAUD_4800);
            `AIO_SEL_19200:  baud_div = 14'(`AIO_CLK_HZ / `AIO_BAUD_19200);
            `AIO_SEL_38400:  baud_div = 14'(`AIO_CLK_HZ / `AIO_BAUD_38400);
            `AIO_SEL_57600:  baud_div = 14'(`AIO_CLK_HZ / `AIO_BAUD_57600);
            `AIO_SEL_115200: baud_div = 14'(`AIO_CLK_HZ / `AIO_BAUD_115200);
            default:         baud_div = 14'(`AIO_CLK_HZ / `AIO_BAUD_9600);
        endcase
    endfunction : baud_div

    // ==========================================================
    // state
    aio_pkg::aio_state_s st;
    aio_pkg::aio_state_s next_st;

    logic        byte_valid;
    logic [13:0] div;
    logic [4:0]  a_hi;
    logic [4:0]  a_lo;
    logic [4:0]  v_hi;
    logic [4:0]  v_lo;
    logic [4:0]  c_hi;
    logic [4:0]  c_lo;
    logic [3:0]  ck_i;
    logic [3:0]  plen;
    logic [7:0]  body_sum;
    logic [7:0]  val;
    logic [2:0]  ch;
    logic        addr_ok;
    logic        ck_ok;
    logic        cmd_ok;
    logic [4:0]  rplen;
    logic [4:0]  total;
    logic [7:0]  rc;
    logic        ap_valid;

    always_comb begin
        next_st = st;
        byte_valid = 1'b0;
        div = baud_div(st.baud_sel);
        cmd_ok = 1'b0;
        ap_valid = hsel && hready && htrans[1];

        // ==========================================================
        // input synchronisers: a change counts once stages two and three agree
        next_st.enc_s1 = {encoder_phase_b_input[3], encoder_phase_a_input[3],
                          encoder_phase_b_input[2], encoder_phase_a_input[2],
                          encoder_phase_b_input[1], encoder_phase_a_input[1],
                          encoder_phase_b_input[0], encoder_phase_a_input[0]};
        next_st.enc_s2 = st.enc_s1;
        next_st.enc_s3 = st.enc_s2;
        next_st.enc = (~(st.enc_s2 ^ st.enc_s3) & st.enc_s3) | ((st.enc_s2 ^ st.enc_s3) & st.enc);
        next_st.rx_s = {st.rx_s[1:0], ~rxd};
        if (st.rx_s[1] == st.rx_s[2]) begin
            next_st.rx_low = st.rx_s[2];
        end
        next_st.init_s = {st.init_s[1:0], init_switch};
        if (st.init_s[1] == st.init_s[2]) begin
            next_st.init_lvl = st.init_s[2];
        end

        // ==========================================================
        // receiver, bit timing restarts on each start edge
        case (st.rx)
            aio_pkg::AIO_RX_IDLE: begin
                if (st.rx_low) begin
                    next_st.rx = aio_pkg::AIO_RX_START;
                    next_st.rx_cnt = div >> 1;
                end
            end
            aio_pkg::AIO_RX_START: begin
                if (st.rx_cnt == 14'h0) begin
                    next_st.rx = st.rx_low ? aio_pkg::AIO_RX_DATA : aio_pkg::AIO_RX_IDLE;
                    next_st.rx_cnt = div - 14'h1;
                    next_st.rx_bit = 3'h0;
                end else begin
                    next_st.rx_cnt = st.rx_cnt - 14'h1;
                end
            end
            aio_pkg::AIO_RX_DATA: begin
                if (st.rx_cnt == 14'h0) begin
                    next_st.rx_sh = {~st.rx_low, st.rx_sh[7:1]};
                    next_st.rx_bit = st.rx_bit + 3'h1;
                    next_st.rx_cnt = div - 14'h1;
                    if (st.rx_bit == 3'h7) begin
                        next_st.rx = aio_pkg::AIO_RX_STOP;
                    end
                end else begin
                    next_st.rx_cnt = st.rx_cnt - 14'h1;
                end
            end
            default: begin
                if (st.rx_cnt == 14'h0) begin
                    // a low stop bit is a framing error and the character is dropped
                    byte_valid = ~st.rx_low;
                    next_st.rx = aio_pkg::AIO_RX_IDLE;
                end else begin
                    next_st.rx_cnt = st.rx_cnt - 14'h1;
                end
            end
        endcase

        // ==========================================================
        // transmitter
        if (st.tx_left != 4'h0) begin
            if (st.tx_cnt == 14'h0) begin
                next_st.tx_sh = {1'b1, st.tx_sh[9:1]};
                next_st.tx_left = st.tx_left - 4'h1;
                next_st.tx_cnt = div - 14'h1;
            end else begin
                next_st.tx_cnt = st.tx_cnt - 14'h1;
            end
        end

        // ==========================================================
        // frame decode terms
        a_hi = hexv(st.fb[1]);
        a_lo = hexv(st.fb[2]);
        v_hi = hexv(st.fb[6]);
        v_lo = hexv(st.fb[7]);
        ck_i = (st.len >= `AIO_LEN_CKMIN) ? st.len - `AIO_CK_CHARS : 4'h0;
        c_hi = hexv(st.fb[ck_i]);
        c_lo = hexv(st.fb[ck_i + 4'h1]);
        body_sum = st.sum - st.fb[ck_i] - st.fb[ck_i + 4'h1];
        plen = st.cksum_en ? st.len - `AIO_CK_CHARS : st.len;
        val = {v_hi[3:0], v_lo[3:0]};
        ch = st.fb[5][2:0];
        addr_ok = a_hi[4] && a_lo[4] && ({a_hi[3:0], a_lo[3:0]} == st.addr);
        ck_ok = !st.cksum_en || (st.len >= `AIO_LEN_CKMIN && c_hi[4] && c_lo[4] &&
                 {c_hi[3:0], c_lo[3:0]} == body_sum);

        // reply character at the current index
        rplen = (st.kind == aio_pkg::AIO_RP_STATUS) ? `AIO_LEN_STATUS : `AIO_LEN_SHORT;
        total = rplen + (st.cksum_en ? 5'h3 : 5'h1);
        rc = `AIO_CH_CR;
        if (st.idx < rplen) begin
            if (st.kind == aio_pkg::AIO_RP_STATUS) begin
                if (st.idx == 5'h0) begin
                    rc = `AIO_CH_GT;
                end else if (st.idx < 5'h9) begin
                    rc = `AIO_CH_ZERO | 8'(st.outs[3'(5'h8 - st.idx)]);
                end else if (st.idx == 5'h9 || st.idx == 5'h12) begin
                    rc = `AIO_CH_COMMA;
                end else if (st.idx < 5'h12) begin
                    rc = `AIO_CH_ZERO | 8'(st.rst_vals[3'(5'h11 - st.idx)]);
                end else begin
                    rc = `AIO_CH_ZERO | 8'(st.enc_snap[3'(5'h1a - st.idx)]);
                end
            end else if (st.idx == 5'h0) begin
                rc = (st.kind == aio_pkg::AIO_RP_ACK) ? `AIO_CH_BANG : `AIO_CH_QUERY;
            end else if (st.idx == 5'h1) begin
                rc = hexc(st.addr[7:4]);
            end else begin
                rc = hexc(st.addr[3:0]);
            end
        end else if (st.cksum_en && st.idx == rplen) begin
            rc = hexc(st.tx_sum[7:4]);
        end else if (st.cksum_en && st.idx == rplen + 5'h1) begin
            rc = hexc(st.tx_sum[3:0]);
        end

        // ==========================================================
        // command state machine
        case (st.main)
            aio_pkg::AIO_M_BOOT: begin
                // wait for the strap synchroniser to settle before sampling it
                next_st.boot_cnt = st.boot_cnt + 2'h1;
                if (st.boot_cnt == `AIO_BOOT_CYCLES) begin
                    // the strap filter restarts with reset, so take the level it settles on now
                    next_st.default_mode = next_st.init_lvl;
                    next_st.addr = next_st.init_lvl ? `AIO_DEFAULT_ADDR : `AIO_FACTORY_ADDR;
                    next_st.baud_sel = `AIO_SEL_9600;
                    next_st.cksum_en = 1'b0;
                    next_st.outs = st.rst_vals;
                    next_st.main = aio_pkg::AIO_M_HUNT;
                end
            end
            aio_pkg::AIO_M_HUNT: begin
                if (byte_valid && (st.rx_sh == `AIO_CH_HASH || st.rx_sh == `AIO_CH_DOLLAR ||
                    st.rx_sh == `AIO_CH_PERCENT || st.rx_sh == `AIO_CH_AT)) begin
                    next_st.fb[0] = st.rx_sh;
                    next_st.len = 4'h1;
                    next_st.sum = st.rx_sh;
                    next_st.ovf = 1'b0;
                    next_st.main = aio_pkg::AIO_M_COLLECT;
                end
            end
            aio_pkg::AIO_M_COLLECT: begin
                if (byte_valid) begin
                    if (st.rx_sh == `AIO_CH_CR) begin
                        next_st.main = aio_pkg::AIO_M_DECODE;
                    end else if (st.len < `AIO_BUF_LEN) begin
                        next_st.fb[st.len] = st.rx_sh;
                        next_st.len = st.len + 4'h1;
                        next_st.sum = st.sum + st.rx_sh;
                    end else begin
                        next_st.ovf = 1'b1;
                    end
                end
            end
            aio_pkg::AIO_M_DECODE: begin
                next_st.idx = 5'h0;
                next_st.tx_sum = 8'h00;
                next_st.kind = aio_pkg::AIO_RP_NAK;
                next_st.main = aio_pkg::AIO_M_REPLY;
                if (!addr_ok || st.len < `AIO_LEN_RDCMD) begin
                    next_st.main = aio_pkg::AIO_M_HUNT;
                end else if (!st.ovf && ck_ok && st.fb[0] == `AIO_CH_HASH) begin
                    if (plen == `AIO_LEN_RDCMD) begin
                        next_st.kind = aio_pkg::AIO_RP_STATUS;
                        next_st.enc_snap = st.enc;
                    end else if (plen == `AIO_LEN_SETCMD && st.fb[3] == `AIO_CH_ONE &&
                                 v_hi[4] && v_lo[4]) begin
                        if (st.fb[4] == `AIO_CH_ZERO && st.fb[5] == `AIO_CH_ZERO) begin
                            next_st.outs = val;
                            cmd_ok = 1'b1;
                        end else if (st.fb[4] == `AIO_CH_F && st.fb[5] == `AIO_CH_F) begin
                            next_st.rst_vals = val;
                            cmd_ok = 1'b1;
                        end else if (st.fb[5] >= `AIO_CH_ZERO && st.fb[5] <= `AIO_CH_SEVEN &&
                                     val[7:1] == 7'h00) begin
                            if (st.fb[4] == `AIO_CH_ONE) begin
                                next_st.outs[ch] = val[0];
                                cmd_ok = 1'b1;
                            end else if (st.fb[4] == `AIO_CH_E) begin
                                next_st.rst_vals[ch] = val[0];
                                cmd_ok = 1'b1;
                            end
                        end
                        if (cmd_ok) begin
                            next_st.kind = aio_pkg::AIO_RP_ACK;
                        end
                    end
                end
            end
            default: begin
                // one character is loaded each time the shifter falls idle
                if (st.tx_left == 4'h0) begin
                    if (st.idx == total) begin
                        next_st.main = aio_pkg::AIO_M_HUNT;
                    end else begin
                        next_st.tx_sh = {1'b1, rc, 1'b0};
                        next_st.tx_left = 4'ha;
                        next_st.tx_cnt = div - 14'h1;
                        next_st.idx = st.idx + 5'h1;
                        if (st.idx < rplen) begin
                            next_st.tx_sum = st.tx_sum + rc;
                        end
                    end
                end
            end
        endcase
        next_st.tx_low = (next_st.tx_left != 4'h0) && !next_st.tx_sh[0];

        // ==========================================================
        // bus slave: zero wait states, writes land in the data phase
        if (st.wr_pend) begin
            if (st.wr_addr == `AIO_REG_CFG) begin
                next_st.addr = hwdata[7:0];
                if (st.default_mode) begin
                    next_st.baud_sel = hwdata[10:8];
                    next_st.cksum_en = hwdata[11];
                end else if (hwdata[10:8] != st.baud_sel || hwdata[11] != st.cksum_en) begin
                    next_st.refused = 1'b1;
                end
            end else if (st.wr_addr == `AIO_REG_STATUS) begin
                // set beats clear when a refusal lands in the same cycle
                if (hwdata[`AIO_ST_REFUSED]) begin
                    next_st.refused = 1'b0;
                end
            end else if (st.wr_addr == `AIO_REG_OUTS) begin
                if (st.main != aio_pkg::AIO_M_DECODE) begin
                    next_st.outs = hwdata[7:0];
                    next_st.rst_vals = hwdata[15:8];
                end
            end
            if (st.wr_addr == `AIO_REG_CFG && !st.default_mode &&
                (hwdata[10:8] != st.baud_sel || hwdata[11] != st.cksum_en)) begin
                next_st.refused = 1'b1;
            end
        end
        next_st.wr_pend = ap_valid && hwrite;
        next_st.wr_addr = haddr[7:0];
        if (ap_valid && !hwrite) begin
            if (haddr[7:0] == `AIO_REG_CFG) begin
                next_st.hrdata = {20'h0, st.cksum_en, st.baud_sel, st.addr};
            end else if (haddr[7:0] == `AIO_REG_STATUS) begin
                next_st.hrdata = {5'h0, st.main != aio_pkg::AIO_M_HUNT, st.refused,
                                  st.default_mode, st.enc, st.rst_vals, st.outs};
            end else if (haddr[7:0] == `AIO_REG_OUTS) begin
                next_st.hrdata = {16'h0, st.rst_vals, st.outs};
            end else begin
                next_st.hrdata = 32'h0;
            end
        end
    end

    // ==========================================================
    // registers; all-zero reset gives factory outputs off and line idle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = st.hrdata;
    assign txd = ~st.tx_low;
    assign tx_busy = (st.tx_left != 4'h0);
    assign switch_output_channels = st.outs;
endmodule : aio_parser

/* aio_parser_sva.sv */
`timescale 1ns/1ps
// ==========================================================
// port checker
module aio_parser_sva (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        rxd,
    input wire logic        txd,
    input wire logic        tx_busy,
    input wire logic [7:0]  switch_output_channels
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic rd_st;
    logic wr_out;
    // address phases registered one edge late, so data-phase checks line up
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_st  <= 1'b0;
            wr_out <= 1'b0;
        end else begin
            rd_st  <= hsel && hready && htrans[1] && !hwrite && haddr[7:0] == 8'h04;
            wr_out <= hsel && hready && htrans[1] && hwrite && haddr[7:0] == 8'h08;
        end
    end
    chk_idle_high: assert property (!tx_busy |-> txd)
        else $error("txd low while idle");
    chk_start_busy: assert property ($fell(txd) |-> tx_busy)
        else $error("start bit outside a character");
    chk_start_len: assert property ($fell(txd) |-> !txd [*8])
        else $error("start bit too short");
    chk_busy_len: assert property ($rose(tx_busy) |-> tx_busy [*8])
        else $error("character too short");
    chk_reply_after: assert property ($rose(tx_busy) |-> $past(rxd, 8))
        else $error("reply began inside an incoming character");
    chk_boot_outs: assert property ($rose(hresetn) |-> switch_output_channels == 8'h00 [*4])
        else $error("outputs not at reset value after reset");
    chk_status_outs: assert property (rd_st |-> hrdata[7:0] == $past(switch_output_channels))
        else $error("status read does not show outputs");
    // a serial set must be answered; bus writes are exempt
    chk_outs_ack: assert property ($changed(switch_output_channels) && !$past(wr_out)
        |-> ##[0:16] $rose(tx_busy))
        else $error("output change without reply");
    cov_reply: cover property ($rose(tx_busy));
    cov_status: cover property (rd_st);
    cov_set: cover property ($changed(switch_output_channels));
endmodule : aio_parser_sva

/* aio_host.sv */
`timescale 1ns/1ps
// ==========================================================
// host end of the serial link, 8N1
module aio_host #(parameter int BIT = 173) (
    input  wire logic hclk,
    input  wire logic from_dev,
    output logic      to_dev
);
    logic [7:0] got[$];
    logic [7:0] b;
    initial to_dev = 1'b1;
    task automatic send(input logic [7:0] c);
        for (int i = 0; i < 10; i++) begin
            to_dev <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : c[i-1];
            repeat (BIT) @(posedge hclk);
        end
    endtask : send
    task automatic frame(input string s);
        for (int i = 0; i < s.len(); i++)
            send(s[i]);
        send(8'h0d);
    endtask : frame
    // sample mid bit so a cycle of edge jitter is harmless
    always begin
        @(negedge from_dev);
        repeat (BIT / 2) @(posedge hclk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge hclk);
            b[i] = from_dev;
        end
        repeat (BIT) @(posedge hclk);
        got.push_back(b);
    end
endmodule : aio_host

/* aio_parser_bench.sv */
`timescale 1ns/1ps
// ==========================================================
// self-checking bench
module aio_parser_bench;
    logic        hclk, hresetn, hwrite, init_switch;
    logic [31:0] haddr, hwdata, rd;
    logic [1:0]  htrans;
    logic [3:0]  enc_a, enc_b;
    wire         hready, hresp, txd, tx_busy, rxd;
    wire  [31:0] hrdata;
    wire  [7:0]  outs;
    int          fail_count, checked;
    aio_parser i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .rxd(rxd), .txd(txd),
        .tx_busy(tx_busy), .init_switch(init_switch), .encoder_phase_a_input(enc_a),
        .encoder_phase_b_input(enc_b), .switch_output_channels(outs));
    aio_host i_host (.hclk(hclk), .from_dev(txd), .to_dev(rxd));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_of_test
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask : bus
    task automatic reply(input string s);
        int n;
        n = 0;
        while (i_host.got.size() <= s.len() && n < 60000) begin
            @(posedge hclk);
            n++;
        end
        for (int i = 0; i <= s.len(); i++)
            check(i_host.got.size() > i ? i_host.got[i] : 8'h00, i < s.len() ? s[i] : 8'h0d);
        i_host.got.delete();
        // let the stop bit finish, the line is half duplex
        repeat (200) @(posedge hclk);
    endtask : reply
    task automatic t_default;
        bus(1'b0, 32'h0, 32'h0);
        check(rd & 32'hfff, 32'h0);
        bus(1'b0, 32'h4, 32'h0);
        check(rd & 32'h10000ff, 32'h1000000);
        bus(1'b1, 32'h0, 32'h600);
        bus(1'b0, 32'h0, 32'h0);
        check(rd & 32'hfff, 32'h600);
        bus(1'b0, 32'hc, 32'h0);
        check(rd, 32'h0);
        check(hresp, 32'h0);
        $display("default state test done");
    endtask : t_default
    task automatic t_set;
        i_host.frame("#00100A5");
        reply("!00");
        check(outs, 32'ha5);
        $display("set outputs test done");
    endtask : t_set
    task automatic t_status;
        string s;
        s = ">10100101,00000000,";
        for (int i = 7; i >= 0; i--)
            s = {s, ((i % 2) ? enc_b[i/2] : enc_a[i/2]) ? "1" : "0"};
        i_host.frame("#00");
        reply(s);
        $display("status test done");
    endtask : t_status
    task automatic t_refuse;
        i_host.frame("#0011209");
        reply("?00");
        check(outs, 32'ha5);
        $display("refusal test done");
    endtask : t_refuse
    task automatic t_strap;
        init_switch <= 1'b0;
        hresetn     <= 1'b0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (8) @(posedge hclk);
        bus(1'b0, 32'h0, 32'h0);
        check(rd & 32'hfff, 32'h1);
        bus(1'b1, 32'h0, 32'h601);
        bus(1'b0, 32'h0, 32'h0);
        check(rd & 32'hfff, 32'h1);
        bus(1'b0, 32'h4, 32'h0);
        check(rd & 32'h30000ff, 32'h2000000);
        bus(1'b1, 32'h4, 32'h2000000);
        bus(1'b0, 32'h4, 32'h0);
        check(rd & 32'h2000000, 32'h0);
        $display("strap and refusal test done");
    endtask : t_strap
    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end
    initial begin
        repeat (105000) @(posedge hclk);
        fail_count++;
        end_of_test();
    end
    initial begin
        {hresetn, hwrite, htrans, haddr, hwdata} = '0;
        init_switch = 1'b1;
        enc_a = 4'h5;
        enc_b = 4'h3;
        fail_count = 0;
        checked = 0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (8) @(posedge hclk);
        t_default();
        t_set();
        t_status();
        t_refuse();
        t_strap();
        end_of_test();
    end
endmodule : aio_parser_bench
bind aio_parser aio_parser_sva i_sva (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .rxd(rxd), .txd(txd), .tx_busy(tx_busy), .switch_output_channels(switch_output_channels));
